// [src/pdc_pkg.sv]
// Shared constants and types for the process data digital I/O configuration block.
// Assumes one system clock; register indices are word indices on the register bus.
package pdc_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [11:0] PORT_INFORMATION_IDX = 12'h14e;
    localparam logic [11:0] DIGITAL_IO_CONFIGURATION_IDX = 12'h150;
    localparam logic [11:0] DIGITAL_IO_PAIR_DIRECTION_IDX = 12'h152;
    localparam logic [11:0] EVENT_STATUS_IDX = 12'h154;
    localparam logic [11:0] EVENT_MASK_IDX = 12'h155;

    // Bit positions in the information word.
    localparam int INFO_ACK_BY_WRITE_BIT = 0;
    localparam int INFO_LOADED_BIT = 1;
    localparam int INFO_ACTIVE_BIT = 2;
    localparam int INFO_INVALID_BIT = 3;

    // Nonvolatile word numbers that feed the configuration.
    localparam logic [7:0] NV_CONFIG_WORD = 8'h01;
    localparam logic [7:0] NV_DIRECTION_WORD = 8'h03;

    // Values after reset.
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [15:0] DIRECTION_RESET = 16'h0000;
    localparam logic [3:0] EVENT_RESET = 4'h0;

    // Event status bit positions.
    localparam int EV_INPUT_SAMPLED = 0;
    localparam int EV_OUTPUT_UPDATED = 1;
    localparam int EV_WATCHDOG_EXPIRED = 2;
    localparam int EV_CONFIG_LOADED = 3;
    localparam int EV_COUNT = 4;

    // Input sampling selection.
    localparam logic [1:0] SAMPLE_FRAME_START = 2'h0;
    localparam logic [1:0] SAMPLE_LATCH_EDGE = 2'h1;
    localparam logic [1:0] SAMPLE_SYNC_A = 2'h2;
    localparam logic [1:0] SAMPLE_SYNC_B = 2'h3;

    // Output update selection.
    localparam logic [1:0] UPDATE_FRAME_END = 2'h0;
    localparam logic [1:0] UPDATE_RESERVED = 2'h1;
    localparam logic [1:0] UPDATE_SYNC_A = 2'h2;
    localparam logic [1:0] UPDATE_SYNC_B = 2'h3;

    // AHB-Lite transfer type bit that marks an active transfer.
    localparam int HTRANS_ACTIVE_BIT = 1;

    // Layout of the digital I/O configuration byte, bit 7 first.
    typedef struct packed {
        logic [1:0] update_sel;
        logic [1:0] sample_sel;
        logic watchdog_late;
        logic bidirectional;
        logic strobe_watchdog;
        logic strobe_active_low;
    } pdc_config_t;

    // Single-cycle events from the frame processing side.
    typedef struct packed {
        logic frame_start;
        logic frame_end;
        logic clock_sync_event_a;
        logic clock_sync_event_b;
        logic process_watchdog_trigger;
        logic watchdog_expired;
    } pdc_events_t;

    // Nonvolatile word delivered by the loader.
    typedef struct packed {
        logic valid;
        logic [7:0] index;
        logic [15:0] data;
    } pdc_nv_word_t;

endpackage : pdc_pkg

// [src/pdc_digital_io.sv]
// Process data digital I/O port: configuration, status and pin timing.
// Assumes events and nonvolatile words arrive on ref_clk_i; pins are asynchronous.
`timescale 1ns/1ps

module pdc_digital_io #(
    parameter int PIN_COUNT = 32,
    parameter bit ACK_BY_WRITE = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Frame processing side
    input wire pdc_pkg::pdc_events_t frame_events_i,
    input wire pdc_pkg::pdc_nv_word_t nv_word_i,
    input wire logic nv_load_done_i,
    input wire logic [PIN_COUNT-1:0] out_data_i,
    output logic [PIN_COUNT-1:0] in_data_o,
    output logic in_sampled_o,
    // Field pins
    input wire logic [PIN_COUNT-1:0] pin_i,
    output logic [PIN_COUNT-1:0] pin_o,
    output logic [PIN_COUNT-1:0] pin_oe_n_o,
    input wire logic latch_in_i,
    output logic output_valid_strobe_o,
    // Interrupt
    output logic irq_o
);

    localparam int PAIR_COUNT = PIN_COUNT / 2;

    initial begin
        if (PIN_COUNT < 2 || PIN_COUNT > 32 || (PIN_COUNT % 2) != 0) begin
            $error("PIN_COUNT must be even and between 2 and 32.");
        end
    end

    pdc_pkg::pdc_config_t config_q;
    logic [15:0] direction_q;
    logic loaded;
    logic [pdc_pkg::EV_COUNT-1:0] event_status;
    logic [pdc_pkg::EV_COUNT-1:0] event_mask;
    logic watchdog_pending;
    logic [PIN_COUNT-1:0] out_value;

    // Pin synchronisers: three stages, a change counts when stages two and three agree.
    logic [PIN_COUNT-1:0] pin_s1;
    logic [PIN_COUNT-1:0] pin_s2;
    logic [PIN_COUNT-1:0] pin_s3;
    logic [PIN_COUNT-1:0] pin_stable;
    logic latch_s1;
    logic latch_s2;
    logic latch_s3;
    logic latch_stable;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            latch_s1 <= 1'b0;
            latch_s2 <= 1'b0;
            latch_s3 <= 1'b0;
        end else begin
            pin_s1 <= pin_i;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            latch_s1 <= latch_in_i;
            latch_s2 <= latch_s1;
            latch_s3 <= latch_s2;
        end
    end

    wire [PIN_COUNT-1:0] pin_agree = ~(pin_s2 ^ pin_s3);
    wire latch_agree = (latch_s2 == latch_s3);
    wire [PIN_COUNT-1:0] next_pin_stable = (pin_stable & ~pin_agree) | (pin_s3 & pin_agree);
    wire next_latch_stable = latch_agree ? latch_s3 : latch_stable;
    wire latch_rise = next_latch_stable & ~latch_stable;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pin_stable <= '0;
            latch_stable <= 1'b0;
        end else begin
            pin_stable <= next_pin_stable;
            latch_stable <= next_latch_stable;
        end
    end

    // Configuration state and loading.
    wire cfg_word = nv_word_i.valid && nv_word_i.index == pdc_pkg::NV_CONFIG_WORD;
    wire dir_word = nv_word_i.valid && nv_word_i.index == pdc_pkg::NV_DIRECTION_WORD;
    // Unused pairs are cut off so stray image bits cannot drive missing pins.
    wire [15:0] dir_used = direction_q & 16'((32'h1 << PAIR_COUNT) - 32'h1);
    // The device does not depend on the image writer; it flags the slip instead.
    wire bidir_dir_set = config_q.bidirectional && direction_q != 16'h0000;
    wire reserved_update = !config_q.strobe_watchdog
        && config_q.update_sel == pdc_pkg::UPDATE_RESERVED;
    wire config_invalid = loaded && (reserved_update || bidir_dir_set);
    wire port_active = loaded && !config_invalid;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            config_q <= pdc_pkg::CONFIG_RESET;
            direction_q <= pdc_pkg::DIRECTION_RESET;
            loaded <= 1'b0;
        end else begin
            if (cfg_word) begin
                config_q <= nv_word_i.data[7:0];
            end
            if (dir_word) begin
                direction_q <= nv_word_i.data;
            end
            if (nv_load_done_i) begin
                loaded <= 1'b1;
            end
        end
    end

    // Input sampling event selection.
    wire sample_event = port_active && (
        (config_q.sample_sel == pdc_pkg::SAMPLE_FRAME_START && frame_events_i.frame_start)
        || (config_q.sample_sel == pdc_pkg::SAMPLE_LATCH_EDGE && latch_rise)
        || (config_q.sample_sel == pdc_pkg::SAMPLE_SYNC_A && frame_events_i.clock_sync_event_a)
        || (config_q.sample_sel == pdc_pkg::SAMPLE_SYNC_B && frame_events_i.clock_sync_event_b)
    );

    // Output event selection; watchdog trigger mode overrides the update field.
    wire field_event =
        (config_q.update_sel == pdc_pkg::UPDATE_FRAME_END && frame_events_i.frame_end)
        || (config_q.update_sel == pdc_pkg::UPDATE_SYNC_A && frame_events_i.clock_sync_event_a)
        || (config_q.update_sel == pdc_pkg::UPDATE_SYNC_B && frame_events_i.clock_sync_event_b);
    wire output_event = port_active && (config_q.strobe_watchdog
        ? frame_events_i.process_watchdog_trigger : field_event);
    wire expire_now = frame_events_i.watchdog_expired && !config_q.watchdog_late;
    wire expire_late = frame_events_i.watchdog_expired && config_q.watchdog_late;
    wire late_clear = output_event && watchdog_pending;
    wire [PIN_COUNT-1:0] next_out_value = (expire_now || late_clear) ? '0
        : (output_event ? out_data_i : out_value);

    // Pin direction: pair bit n steers pins 2n and 2n+1.
    logic [PIN_COUNT-1:0] pin_is_output;
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_dir
            assign pin_is_output[gi] = dir_used[gi/2];
        end
    endgenerate
    // Bidirectional pins only drive their set bits, so a low bit leaves the line readable.
    wire [PIN_COUNT-1:0] drive = !port_active ? '0
        : (config_q.bidirectional ? next_out_value : pin_is_output);

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            out_value <= '0;
            watchdog_pending <= 1'b0;
            pin_o <= '0;
            pin_oe_n_o <= '1;
            in_data_o <= '0;
            in_sampled_o <= 1'b0;
            output_valid_strobe_o <= 1'b0;
        end else begin
            out_value <= next_out_value;
            // A new late expiry wins over the clear of an older one.
            watchdog_pending <= expire_late || (watchdog_pending && !output_event);
            pin_o <= next_out_value;
            pin_oe_n_o <= ~drive;
            if (sample_event) begin
                in_data_o <= next_pin_stable;
            end
            in_sampled_o <= sample_event;
            output_valid_strobe_o <= config_q.strobe_active_low ^ output_event;
        end
    end

    // Register bus: one wait state so read data leaves a flip-flop.
    logic data_phase;
    logic data_write;
    logic [11:0] data_index;
    wire take = hsel_i && hready_i && htrans_i[pdc_pkg::HTRANS_ACTIVE_BIT];

    function automatic logic hit(input logic [11:0] idx, input logic [11:0] reg_idx);
        hit = (idx == reg_idx);
    endfunction : hit

    wire [15:0] info_word = {12'h000, config_invalid, port_active, loaded, ACK_BY_WRITE};
    wire status_wr = data_phase && data_write && hit(data_index, pdc_pkg::EVENT_STATUS_IDX);
    wire mask_wr = data_phase && data_write && hit(data_index, pdc_pkg::EVENT_MASK_IDX);
    wire [pdc_pkg::EV_COUNT-1:0] event_set = {nv_load_done_i,
        frame_events_i.watchdog_expired, output_event, sample_event};
    wire [pdc_pkg::EV_COUNT-1:0] status_clear = status_wr
        ? hwdata_i[pdc_pkg::EV_COUNT-1:0] : '0;
    wire [pdc_pkg::EV_COUNT-1:0] next_status = event_set | (event_status & ~status_clear);

    wire [31:0] read_word =
        hit(data_index, pdc_pkg::PORT_INFORMATION_IDX) ? {16'h0000, info_word}
        : hit(data_index, pdc_pkg::DIGITAL_IO_CONFIGURATION_IDX) ? {24'h000000, config_q}
        : hit(data_index, pdc_pkg::DIGITAL_IO_PAIR_DIRECTION_IDX) ? {16'h0000, direction_q}
        : hit(data_index, pdc_pkg::EVENT_STATUS_IDX) ? {28'h0000000, event_status}
        : hit(data_index, pdc_pkg::EVENT_MASK_IDX) ? {28'h0000000, event_mask}
        : 32'h00000000;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            data_phase <= 1'b0;
            data_write <= 1'b0;
            data_index <= 12'h000;
            hreadyout_o <= 1'b1;
            hrdata_o <= 32'h00000000;
            hresp_o <= 1'b0;
        end else begin
            data_phase <= take;
            hreadyout_o <= !take;
            hresp_o <= 1'b0;
            if (take) begin
                data_write <= hwrite_i;
                data_index <= haddr_i[13:2];
            end
            if (data_phase && !data_write) begin
                hrdata_o <= read_word;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            event_status <= pdc_pkg::EVENT_RESET;
            event_mask <= pdc_pkg::EVENT_RESET;
            irq_o <= 1'b0;
        end else begin
            event_status <= next_status;
            if (mask_wr) begin
                event_mask <= hwdata_i[pdc_pkg::EV_COUNT-1:0];
            end
            irq_o <= |(next_status & event_mask);
        end
    end

endmodule : pdc_digital_io

// [test/pdc_field_model.sv]
// Field side of the digital pins: resolves each pin from driver and field value.
// Assumes the block drives a pin only while its enable is low.
`timescale 1ns/1ps
module pdc_field_model #(
    parameter int PIN_COUNT = 32
) (
    // Block side
    input wire logic [PIN_COUNT-1:0] pin_o,
    input wire logic [PIN_COUNT-1:0] pin_oe_n_o,
    // Field side
    input wire logic [PIN_COUNT-1:0] field_i,
    output logic [PIN_COUNT-1:0] pin_i
);
    // A released pin shows the field level, never the last driven value.
    assign pin_i = (pin_o & ~pin_oe_n_o) | (field_i & pin_oe_n_o);
endmodule : pdc_field_model

// [test/pdc_digital_io_asserts.sv]
// Port checker for the digital I/O block, bound into every instance.
// Assumes the configuration words arrive once after each reset.
`timescale 1ns/1ps
module pdc_digital_io_asserts #(
    parameter int PIN_COUNT = 32
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire pdc_pkg::pdc_events_t frame_events_i,
    input wire pdc_pkg::pdc_nv_word_t nv_word_i,
    input wire logic nv_load_done_i,
    input wire logic [PIN_COUNT-1:0] out_data_i,
    input wire logic [PIN_COUNT-1:0] pin_o,
    input wire logic [PIN_COUNT-1:0] pin_oe_n_o,
    input wire logic in_sampled_o,
    input wire logic output_valid_strobe_o,
    input wire logic irq_o
);
    pdc_pkg::pdc_config_t cfg;
    pdc_pkg::pdc_events_t ev;
    logic [15:0] dir;
    logic ld, act_q, oev_q, pend;
    logic [PIN_COUNT-1:0] dexp;
    assign ev = frame_events_i;
    wire [3:0] uh = {ev.clock_sync_event_b, ev.clock_sync_event_a, 1'b0, ev.frame_end};
    wire [3:0] sh = {ev.clock_sync_event_b, ev.clock_sync_event_a, 1'b0, ev.frame_start};
    wire bad = (!cfg.strobe_watchdog && cfg.update_sel == 2'h1) || (cfg.bidirectional && |dir);
    wire act = ld && !bad;
    wire oev = act && (cfg.strobe_watchdog ? ev.process_watchdog_trigger : uh[cfg.update_sel]);
    wire smp = act && sh[cfg.sample_sel];
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_dir
        assign dexp[i] = dir[i/2];
    end
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            {cfg, dir, ld, act_q, oev_q, pend} <= '0;
        end else begin
            if (nv_word_i.valid && nv_word_i.index == pdc_pkg::NV_CONFIG_WORD) cfg <= nv_word_i.data[7:0];
            if (nv_word_i.valid && nv_word_i.index == pdc_pkg::NV_DIRECTION_WORD) dir <= nv_word_i.data;
            if (nv_load_done_i) ld <= 1'b1;
            act_q <= act;
            oev_q <= oev;
            // A new late expiry wins over the clear by an output event in the same cycle.
            pend <= (ev.watchdog_expired && cfg.watchdog_late) || (pend && !oev);
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    bus_wait_a: assert property (hsel_i && hready_i && htrans_i[1] |=> !hreadyout_o ##1 hreadyout_o)
        else $error("bus transfer did not take one wait state");
    reset_idle_a: assert property ($fell(reset_i) |-> &pin_oe_n_o && !irq_o && !output_valid_strobe_o)
        else $error("outputs not idle after reset");
    upd_load_a: assert property (oev && !pend && !ev.watchdog_expired |=> pin_o == $past(out_data_i))
        else $error("output event did not load pins");
    wd_ignore_a: assert property (act && cfg.strobe_watchdog && !ev.process_watchdog_trigger
        && !ev.watchdog_expired |=> $stable(pin_o))
        else $error("pins changed without trigger");
    wd_now_a: assert property (act && ev.watchdog_expired && !cfg.watchdog_late |=> pin_o == '0)
        else $error("expiry did not clear pins");
    wd_late_a: assert property (oev && pend |=> pin_o == '0)
        else $error("late expiry did not clear pins");
    strobe_pol_a: assert property (oev |=> output_valid_strobe_o != cfg.strobe_active_low)
        else $error("no strobe on output update");
    strobe_idle_a: assert property (act_q && !oev_q |-> output_valid_strobe_o == cfg.strobe_active_low)
        else $error("strobe idle level wrong");
    dir_pair_a: assert property (act_q && !cfg.bidirectional |-> pin_oe_n_o == ~dexp)
        else $error("pin direction wrong");
    bidir_drv_a: assert property (act_q && cfg.bidirectional |-> &(pin_oe_n_o | pin_o))
        else $error("bidirectional pin driven low");
    sample_a: assert property (smp |=> in_sampled_o)
        else $error("sample event missed");
    late_c: cover property (oev && pend);
    smp_c: cover property (smp);
    bidir_c: cover property (act && cfg.bidirectional);
endmodule : pdc_digital_io_asserts

bind pdc_digital_io pdc_digital_io_asserts #(.PIN_COUNT(PIN_COUNT)) u_chk (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .frame_events_i(frame_events_i),
    .nv_word_i(nv_word_i), .nv_load_done_i(nv_load_done_i), .out_data_i(out_data_i),
    .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .in_sampled_o(in_sampled_o),
    .output_valid_strobe_o(output_valid_strobe_o), .irq_o(irq_o));

// [test/pdc_digital_io_tb_top.sv]
// Self-checking bench: random configurations, events, samples and interrupts.
// Assumes the field model resolves pins; each configuration starts from reset.
`timescale 1ns/1ps
module pdc_digital_io_tb_top;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel = 1'b0, hw = 1'b0, done = 1'b0, latch = 1'b0;
    logic [1:0] htr = 2'h0;
    logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, rd;
    logic hrdy, hresp, irq, smp, stb;
    // The strobe stands for one cycle only, so it is captured right after its launching edge.
    logic stb_seen = 1'b0;
    pdc_pkg::pdc_events_t ev = '0;
    pdc_pkg::pdc_nv_word_t nvw = '0;
    logic [31:0] od = 32'h0, fld = 32'h0, pin_i, pin_o, oe_n, ind;
    int error_cnt = 0, num_checks = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    pdc_digital_io #(.PIN_COUNT(32), .ACK_BY_WRITE(1'b1)) dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(ha), .htrans_i(htr),
        .hwrite_i(hw), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hrdy), .hrdata_o(hrd),
        .hreadyout_o(hrdy), .hresp_o(hresp), .frame_events_i(ev), .nv_word_i(nvw),
        .nv_load_done_i(done), .out_data_i(od), .in_data_o(ind), .in_sampled_o(smp),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(oe_n), .latch_in_i(latch),
        .output_valid_strobe_o(stb), .irq_o(irq));
    pdc_field_model #(.PIN_COUNT(32)) field (.pin_o(pin_o), .pin_oe_n_o(oe_n), .field_i(fld),
        .pin_i(pin_i));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wrap_up();
        if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    task automatic bus(input logic [11:0] idx, input logic w, input logic [31:0] d);
        @(posedge ref_clk_i);
        hsel <= 1'b1;
        ha <= {18'h0, idx, 2'h0};
        htr <= 2'h2;
        hw <= w;
        do @(posedge ref_clk_i); while (hrdy !== 1'b1);
        htr <= 2'h0;
        hwd <= d;
        do @(posedge ref_clk_i); while (hrdy !== 1'b1);
        rd = hrd;
        hsel <= 1'b0;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : bus
    task automatic pulse(input logic [5:0] m);
        @(posedge ref_clk_i);
        ev <= pdc_pkg::pdc_events_t'(m);
        @(posedge ref_clk_i);
        ev <= '0;
        #1;
        stb_seen = stb;
        @(posedge ref_clk_i);
        #1;
    endtask : pulse
    task automatic load(input logic [7:0] c, input logic [15:0] d);
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        latch <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        bus(pdc_pkg::PORT_INFORMATION_IDX, 1'b0, 32'h0);
        chk("info_reset", rd, 32'h1);
        bus(pdc_pkg::DIGITAL_IO_CONFIGURATION_IDX, 1'b0, 32'h0);
        chk("cfg_reset", rd, 32'h0);
        nvw <= {1'b1, pdc_pkg::NV_CONFIG_WORD, 8'h00, c};
        @(posedge ref_clk_i);
        nvw <= {1'b1, pdc_pkg::NV_DIRECTION_WORD, d};
        @(posedge ref_clk_i);
        nvw <= '0;
        done <= 1'b1;
        @(posedge ref_clk_i);
        done <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask : load
    function automatic logic [5:0] upd_mask(input logic [7:0] c);
        if (c[1]) return 6'h02;
        case (c[7:6])
            2'h0: return 6'h10;
            2'h2: return 6'h08;
            2'h3: return 6'h04;
            default: return 6'h00;
        endcase
    endfunction : upd_mask
    initial begin
        #100000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        logic [7:0] c;
        logic [15:0] d;
        logic [31:0] dm, ie, pexp;
        logic [5:0] um;
        logic act, h;
        void'($urandom(32'hf3dbb1f2));
        for (int k = 0; k < 12; k++) begin
            c = (k == 0) ? 8'h40 : (k == 1) ? 8'h04 : (k == 2) ? 8'h0b : 8'($urandom);
            d = (k == 1) ? 16'h0001 : c[2] ? 16'h0 : 16'($urandom);
            load(c, d);
            ie = {28'h0, (!c[1] && c[7:6] == 2'h1) || (c[2] && d != 16'h0), 3'h3};
            ie[2] = !ie[3];
            act = ie[2];
            um = upd_mask(c);
            for (int i = 0; i < 32; i++) dm[i] = d[i/2];
            bus(pdc_pkg::PORT_INFORMATION_IDX, 1'b0, 32'h0);
            chk("info", rd, ie);
            bus(pdc_pkg::DIGITAL_IO_CONFIGURATION_IDX, 1'b1, 32'hff);
            bus(pdc_pkg::DIGITAL_IO_CONFIGURATION_IDX, 1'b0, 32'h0);
            chk("cfg", rd, {24'h0, c});
            bus(pdc_pkg::DIGITAL_IO_PAIR_DIRECTION_IDX, 1'b0, 32'h0);
            chk("dir", rd, {16'h0, d});
            bus(12'h3f0, 1'b0, 32'h0);
            chk("unmapped", rd, 32'h0);
            bus(pdc_pkg::EVENT_STATUS_IDX, 1'b0, 32'h0);
            chk("status", rd, 32'h8);
            chk("irq_masked", {31'h0, irq}, 32'h0);
            bus(pdc_pkg::EVENT_MASK_IDX, 1'b1, 32'h8);
            repeat (2) @(posedge ref_clk_i);
            chk("irq_on", {31'h0, irq}, 32'h1);
            bus(pdc_pkg::EVENT_STATUS_IDX, 1'b1, 32'h8);
            repeat (2) @(posedge ref_clk_i);
            chk("irq_off", {31'h0, irq}, 32'h0);
            fld <= $urandom;
            pexp = 32'h0;
            for (int e = 0; e < 4; e++) begin
                od <= $urandom;
                pulse(6'h10 >> e);
                h = act && um == (6'h10 >> e);
                if (h) pexp = od;
                chk("pins", pin_o, pexp);
                if (act) chk("strobe", {31'h0, stb_seen}, {31'h0, c[0] ^ h});
            end
            pulse(6'h01);
            if (act && !c[3]) pexp = 32'h0;
            chk("expire", pin_o, pexp);
            if (act && c[3]) begin
                pulse(um);
                pexp = 32'h0;
                chk("late_clear", pin_o, pexp);
                chk("late_strobe", {31'h0, stb_seen}, {31'h0, !c[0]});
            end
            chk("oe_n", oe_n, !act ? 32'hffffffff : c[2] ? ~pexp : ~dm);
            repeat (6) @(posedge ref_clk_i);
            @(posedge ref_clk_i);
            if (c[5:4] == 2'h1) begin
                latch <= 1'b1;
            end else begin
                ev <= pdc_pkg::pdc_events_t'(c[5:4] == 2'h0 ? 6'h20
                    : c[5:4] == 2'h2 ? 6'h08 : 6'h04);
                @(posedge ref_clk_i);
                ev <= '0;
            end
            for (int t = 0; t < 12 && smp !== 1'b1; t++) @(posedge ref_clk_i);
            if (act) begin
                chk("sampled", {31'h0, smp}, 32'h1);
                chk("in_data", ind, c[2] ? (fld | pexp) : (dm & pexp) | (~dm & fld));
            end
        end
        wrap_up();
    end
endmodule : pdc_digital_io_tb_top
